// ==== rtl/wwdt_pkg.sv ====
// Package for the windowed watchdog timer: constants and carrier types
package wwdt_pkg;

  // Timing: low-power clock nominal rate and system clock
  localparam int LOW_OSC_HZ     = 31000;
  localparam int CLOCK_MHZ      = 125;
  localparam int CLOCK_NS       = 8;
  // Prescaler ratios and nominal periods
  localparam int PRE_DIV_SHORT  = 32;
  localparam int PRE_DIV_LONG   = 128;
  localparam int PERIOD_SHORT_MS = 1;
  localparam int PERIOD_LONG_MS  = 4;
  // Postscaler field
  localparam int POST_SEL_W     = 4;
  localparam int POST_SEL_LSB   = 0;
  localparam int POST_MAX_LOG2  = 15;
  // Configuration word one bit positions
  localparam int CFG_WINDOW_DIS_BIT = 6;
  localparam int CFG_PRESCALE_BIT   = 4;
  localparam int CFG_HW_EN_BIT      = 7;
  // Reset-control register bit positions
  localparam int RCR_IDLE_BIT   = 2;
  localparam int RCR_SLEEP_BIT  = 3;
  localparam int RCR_TIMEOUT_BIT = 4;
  localparam int RCR_SWEN_BIT   = 5;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] ADDR_RCR    = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_COUNT  = 8'h10;
  // Reset values
  localparam logic [15:0] CFG_RESET   = 16'h008f;
  localparam logic [1:0]  MASK_RESET  = 2'h0;
  // Status event bits
  localparam int EV_TIMEOUT = 0;
  localparam int EV_EARLY   = 1;

  // Core event carrier
  typedef struct packed {
    logic clear_instr;
    logic save_sleep;
    logic save_idle;
    logic wake;
    logic clk_switch_done;
  } wwdt_core_ev_t;

  // Wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wwdt_wb_req_t;

endpackage : wwdt_pkg

// ==== rtl/wwdt_top.sv ====
// Windowed watchdog timer with its registers on classic Wishbone
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int PRE_LONG_W = 7
) (
  // System clock and reset
  input  wire logic                   CLOCK,
  input  wire logic                   RESET,
  // Low-power oscillator, sampled as an asynchronous input
  input  wire logic                   LOW_OSC_TICK,
  output logic                        LOW_OSC_ENABLE,
  // Core events and power state
  input  wire wwdt_pkg::wwdt_core_ev_t CORE_EV,
  input  wire logic                   IN_SLEEP,
  input  wire logic                   IN_IDLE,
  // Watchdog outputs
  output logic                        DOG_RESET_REQ,
  output logic                        DOG_WAKE,
  output logic                        IRQ,
  // Wishbone slave
  input  wire wwdt_pkg::wwdt_wb_req_t WB_REQ,
  output logic [31:0]                 WB_DAT_O,
  output logic                        WB_ACK_O
);
  import wwdt_pkg::*;

  // Timeout arithmetic assumes a seven-bit long prescaler
  if (PRE_LONG_W != 7) begin : g_bad_pre_w
    $error("PRE_LONG_W must be 7");
  end

  localparam int CNT_W = PRE_LONG_W + POST_MAX_LOG2 + 1;

  typedef struct packed {
    logic [1:0]       tick_sync;
    logic             tick_last;
    logic [1:0]       clr_sync;
    logic             clr_last;
    logic             clr_tog;
    logic [CNT_W-1:0] count;
    logic [15:0]      cfg;
    logic             sw_en;
    logic             sleep_st;
    logic             idle_st;
    logic             to_flag;
    logic [1:0]       status;
    logic [1:0]       mask;
    logic             rst_req;
    logic             wake;
    logic [31:0]      rdata;
    logic             ack;
  } wwdt_state_t;

  wwdt_state_t st;
  wwdt_state_t next_st;

  // Timeout count from prescale and postscale selection
  function automatic logic [CNT_W-1:0] limit_of(logic [15:0] c);
    logic [4:0] sh;
    sh = c[CFG_PRESCALE_BIT] ? 5'd7 : 5'd5;
    sh = sh + 5'(c[POST_SEL_LSB +: POST_SEL_W]);
    return CNT_W'(1) << sh;
  endfunction : limit_of

  // Read image of a register; unmapped offsets read as zero
  function automatic logic [31:0] read_word(logic [7:0] a, wwdt_state_t s);
    logic [31:0] w;
    w = '0;
    unique case (a)
      ADDR_RCR: begin
        w[RCR_IDLE_BIT]    = s.idle_st;
        w[RCR_SLEEP_BIT]   = s.sleep_st;
        w[RCR_TIMEOUT_BIT] = s.to_flag;
        w[RCR_SWEN_BIT]    = s.sw_en;
      end
      ADDR_CFG:    w[15:0]      = s.cfg;
      ADDR_STATUS: w[1:0]       = s.status;
      ADDR_MASK:   w[1:0]       = s.mask;
      ADDR_COUNT:  w[CNT_W-1:0] = s.count;
      default: ;
    endcase
    return w;
  endfunction : read_word

  logic             dog_on;
  logic [CNT_W-1:0] limit;
  logic             win_open;
  logic             wr;
  logic             rd_hit;
  logic             clr_ev;
  logic             base_clear;
  logic             lp_tick;

  always_comb begin
    dog_on  = st.cfg[CFG_HW_EN_BIT] | st.sw_en;
    limit   = limit_of(st.cfg);
    // Last quarter of the period: count at or above three quarters
    win_open = st.count >= (limit - (limit >> 2));
    wr     = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & ~st.ack;
    rd_hit = WB_REQ.cyc & WB_REQ.stb & ~st.ack;
    // Clear events land on the slow side through a toggle crossing
    clr_ev = st.clr_sync[1] ^ st.clr_last;
    lp_tick = st.tick_sync[1] & ~st.tick_last;
    base_clear = CORE_EV.clk_switch_done | CORE_EV.save_sleep
               | CORE_EV.save_idle | CORE_EV.wake;
  end

  always_comb begin
    logic tick;
    logic timeout;
    logic early;
    tick    = 1'b0;
    timeout = 1'b0;
    early   = 1'b0;
    next_st = st;
    next_st.ack  = rd_hit;
    next_st.wake = 1'b0;
    // Tick edge detect after the second stage only
    next_st.tick_sync = {st.tick_sync[0], LOW_OSC_TICK};
    next_st.tick_last = st.tick_sync[1];
    tick = lp_tick;
    next_st.clr_sync = {st.clr_sync[0], st.clr_tog};
    if (tick) begin
      next_st.clr_last = st.clr_sync[1];
    end
    // Clear instruction: window check happens against the live count
    if (CORE_EV.clear_instr && !st.sleep_st && !st.idle_st) begin
      if (dog_on && !st.cfg[CFG_WINDOW_DIS_BIT] && !win_open) begin
        early = 1'b1;
      end else begin
        next_st.clr_tog = ~st.clr_tog;
      end
    end
    if (CORE_EV.save_sleep) next_st.sleep_st = 1'b1;
    if (CORE_EV.save_idle)  next_st.idle_st  = 1'b1;
    if (base_clear) begin
      next_st.count = '0;
    end else if (tick && clr_ev) begin
      next_st.count = '0;
    end else if (tick && dog_on) begin
      if (st.count + CNT_W'(1) >= limit) begin
        timeout = 1'b1;
        next_st.count = '0;
      end else begin
        next_st.count = st.count + CNT_W'(1);
      end
    end
    // Register writes; hardware set beats software clear, except the sleep and idle saves, which a write overrides
    if (wr) begin
      unique case (WB_REQ.adr)
        ADDR_RCR: if (WB_REQ.sel[0]) begin
          next_st.idle_st  = WB_REQ.dat[RCR_IDLE_BIT];
          next_st.sleep_st = WB_REQ.dat[RCR_SLEEP_BIT];
          next_st.to_flag  = WB_REQ.dat[RCR_TIMEOUT_BIT];
          next_st.sw_en    = WB_REQ.dat[RCR_SWEN_BIT];
          next_st.rst_req  = 1'b0;
        end
        ADDR_CFG: begin
          if (WB_REQ.sel[0]) next_st.cfg[7:0]  = WB_REQ.dat[7:0];
          if (WB_REQ.sel[1]) next_st.cfg[15:8] = WB_REQ.dat[15:8];
        end
        ADDR_STATUS: if (WB_REQ.sel[0])
          next_st.status = st.status & ~WB_REQ.dat[1:0];
        ADDR_MASK: if (WB_REQ.sel[0])
          next_st.mask = WB_REQ.dat[1:0];
        default: ;
      endcase
    end
    // After the writes, so a same-cycle clear cannot hide an event
    if (timeout || early) begin
      if ((st.sleep_st || st.idle_st) && !early) begin
        next_st.wake = 1'b1;
      end else begin
        next_st.rst_req = 1'b1;
      end
      next_st.to_flag = 1'b1;
      next_st.status[EV_TIMEOUT] = 1'b1;
    end
    if (early) next_st.status[EV_EARLY] = 1'b1;
    next_st.rdata = read_word(WB_REQ.adr, st);
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st     <= '0;
      st.cfg <= CFG_RESET;
      st.mask <= MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign LOW_OSC_ENABLE = dog_on;
  assign DOG_RESET_REQ = st.rst_req;
  assign DOG_WAKE      = st.wake;
  assign IRQ           = |(st.status & st.mask);
  assign WB_DAT_O      = st.rdata;
  assign WB_ACK_O      = st.ack;

  // Assertions
  a_enable_follows: assert property (@(posedge CLOCK) disable iff (RESET)
    LOW_OSC_ENABLE == (st.cfg[CFG_HW_EN_BIT] | st.sw_en))
    else $error("oscillator enable wrong");

  a_flag_sticky: assert property (@(posedge CLOCK) disable iff (RESET)
    st.to_flag && !wr |=> st.to_flag)
    else $error("timeout flag dropped");

  a_early_reset: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.clear_instr && dog_on && !st.cfg[CFG_WINDOW_DIS_BIT]
    && !win_open && !st.sleep_st && !st.idle_st |=> DOG_RESET_REQ)
    else $error("early clear not reset");

  a_early_status: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.clear_instr && dog_on && !st.cfg[CFG_WINDOW_DIS_BIT]
    && !win_open && !st.sleep_st && !st.idle_st
    |=> st.status[EV_EARLY])
    else $error("early clear not logged");

  a_window_clear: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.clear_instr && !st.sleep_st && !st.idle_st
    && (win_open || st.cfg[CFG_WINDOW_DIS_BIT])
    |=> st.clr_tog != $past(st.clr_tog))
    else $error("allowed clear not taken");

  a_no_window: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.clear_instr && st.cfg[CFG_WINDOW_DIS_BIT]
    |=> !$rose(st.status[EV_EARLY]))
    else $error("early clear with window off");

  // Clears during power save would hide a stuck core
  a_save_ignores: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.clear_instr && (st.sleep_st || st.idle_st)
    |=> $stable(st.clr_tog))
    else $error("clear taken in power save");

  a_clear_lands: assert property (@(posedge CLOCK) disable iff (RESET)
    lp_tick && clr_ev |=> st.count == '0)
    else $error("clear did not zero count");

  a_switch_clear: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.clk_switch_done |=> st.count == '0)
    else $error("switch did not zero count");

  a_count_step: assert property (@(posedge CLOCK) disable iff (RESET)
    lp_tick && dog_on && !base_clear && !clr_ev
    && (st.count + CNT_W'(1) < limit)
    |=> st.count == $past(st.count) + CNT_W'(1))
    else $error("count did not step");

  a_run_timeout: assert property (@(posedge CLOCK) disable iff (RESET)
    lp_tick && dog_on && !base_clear && !clr_ev
    && (st.count + CNT_W'(1) >= limit) && !st.sleep_st && !st.idle_st
    |=> DOG_RESET_REQ && st.to_flag)
    else $error("running timeout missed");

  a_req_flag: assert property (@(posedge CLOCK) disable iff (RESET)
    $rose(DOG_RESET_REQ) |-> st.to_flag && st.status[EV_TIMEOUT])
    else $error("request without flag");

  a_wake_flag: assert property (@(posedge CLOCK) disable iff (RESET)
    DOG_WAKE |-> st.to_flag && !$rose(DOG_RESET_REQ))
    else $error("wake without flag or with reset");

  a_wake_pulse: assert property (@(posedge CLOCK) disable iff (RESET)
    DOG_WAKE |=> !DOG_WAKE)
    else $error("wake longer than a cycle");

  a_off_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
    !dog_on |=> !$rose(DOG_RESET_REQ))
    else $error("request while disabled");

  a_sleep_track: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.save_sleep && !wr |=> st.sleep_st)
    else $error("sleep state not kept");

  a_idle_track: assert property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.save_idle && !wr |=> st.idle_st)
    else $error("idle state not kept");

  a_ack_cause: assert property (@(posedge CLOCK) disable iff (RESET)
    WB_ACK_O |-> $past(WB_REQ.cyc && WB_REQ.stb))
    else $error("ack without request");

  a_power_clear: assert property (@(posedge CLOCK) disable iff (RESET)
    base_clear |=> st.count == '0)
    else $error("counter not cleared");
  a_count_bound: assert property (@(posedge CLOCK) disable iff (RESET)
    st.count < limit || $changed(st.cfg))
    else $error("counter past limit");
  a_sleep_wake: assert property (@(posedge CLOCK) disable iff (RESET)
    DOG_WAKE |-> $past(st.sleep_st) || $past(st.idle_st))
    else $error("wake outside power save");
  a_off_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    !dog_on && !base_clear && !clr_ev |=> $stable(st.count))
    else $error("counter ran while off");
  a_ack_drop: assert property (@(posedge CLOCK) disable iff (RESET)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held");
  c_timeout: cover property (@(posedge CLOCK) disable iff (RESET)
    DOG_RESET_REQ);
  c_wake: cover property (@(posedge CLOCK) disable iff (RESET) DOG_WAKE);
  c_irq: cover property (@(posedge CLOCK) disable iff (RESET) IRQ);
  c_early: cover property (@(posedge CLOCK) disable iff (RESET)
    $rose(st.status[EV_EARLY]));
  c_window_clear: cover property (@(posedge CLOCK) disable iff (RESET)
    CORE_EV.clear_instr && win_open && !st.cfg[CFG_WINDOW_DIS_BIT]);

endmodule : wwdt_top

// ==== testbench/wwdt_core_model.sv ====
// Core model: issues clear, power-save, wake and switch events
`timescale 1ns/1ps
module wwdt_core_model
  import wwdt_pkg::*;
(
  // Clock
  input  wire logic               clock,
  // Events toward the watchdog
  output wwdt_pkg::wwdt_core_ev_t core_ev
);
  initial core_ev = '0;
  // Bit 4 clear, 3 sleep, 2 idle, 1 wake, 0 switch done
  task automatic issue(input int kind);
    @(posedge clock);
    core_ev <= wwdt_core_ev_t'(5'h1 << kind);
    @(posedge clock);
    core_ev <= '0;
  endtask : issue
endmodule : wwdt_core_model

// ==== testbench/test_windowed_watchdog_timer.sv ====
// Testbench for the windowed watchdog timer
`timescale 1ns/1ps
module test_windowed_watchdog_timer;
  import wwdt_pkg::*;
  logic          clock = 1'b0;
  logic          reset = 1'b1;
  logic [1:0]    div   = 2'h0;
  wwdt_core_ev_t core_ev;
  wwdt_wb_req_t  wb_req = '0;
  logic [31:0]   wb_dat, rd;
  logic          low_osc_en, rst_req, wake, irq, ack;
  logic          in_sleep = 1'b0;
  logic          in_idle  = 1'b0;
  int            num_errors  = 0;
  int            check_count = 0;
  int            wakes = 0;
  int            w;
  int            cycles = 0;

  always #4 clock = ~clock;
  // Tick every four clocks keeps the periods short
  always @(posedge clock) div <= div + 2'h1;
  always @(negedge clock) if (wake === 1'b1) wakes++;
  // Power state as the core sees it
  always @(posedge clock) begin
    if (core_ev.save_sleep) in_sleep <= 1'b1;
    if (core_ev.save_idle) in_idle <= 1'b1;
    if (core_ev.wake) begin
      in_sleep <= 1'b0;
      in_idle  <= 1'b0;
    end
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  wwdt_top #(.PRE_LONG_W(7)) u_wwdt_top (
    .CLOCK(clock), .RESET(reset), .LOW_OSC_TICK(div[1]),
    .LOW_OSC_ENABLE(low_osc_en), .CORE_EV(core_ev), .IN_SLEEP(in_sleep),
    .IN_IDLE(in_idle), .DOG_RESET_REQ(rst_req), .DOG_WAKE(wake),
    .IRQ(irq), .WB_REQ(wb_req), .WB_DAT_O(wb_dat), .WB_ACK_O(ack));
  wwdt_core_model u_wwdt_core_model (.clock(clock), .core_ev(core_ev));

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Ack is registered; sampled on the rising edge, released at that edge
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock);
    wb_req <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n == 20) num_errors++;
    rd = wb_dat;
    wb_req <= '0;
  endtask : wb

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp,
                       input string nm);
    wb(1'b0, adr, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk

  task automatic ticks(input int n);
    repeat (n * 4) @(posedge clock);
  endtask : ticks

  // Clears status and reset-control state, then restarts the count
  task automatic restart();
    wb(1'b1, ADDR_STATUS, 32'h3);
    wb(1'b1, ADDR_RCR, 32'h0);
    u_wwdt_core_model.issue(4);
  endtask : restart

  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rdchk(ADDR_CFG, 32'h8f, "cfg");
    rdchk(ADDR_RCR, 32'h0, "rcr");
    chk("osc_en", low_osc_en, 1'b1);
    rdchk(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    wb(1'b1, ADDR_CFG, 32'hc0);
    restart();
    ticks(28);
    chk("early_rst", rst_req, 1'b0);
    ticks(8);
    chk("rst", rst_req, 1'b1);
    rdchk(ADDR_RCR, 32'h10, "flag");
    wb(1'b1, ADDR_MASK, 32'h3);
    chk("irq", irq, 1'b1);
    wb(1'b1, ADDR_STATUS, 32'h1);
    chk("irq_off", irq, 1'b0);
    restart();
    ticks(20);
    u_wwdt_core_model.issue(4);
    ticks(20);
    u_wwdt_core_model.issue(0);
    ticks(20);
    chk("alive", rst_req, 1'b0);
    $display("test timeout done");
    wb(1'b1, ADDR_CFG, 32'hd0);
    restart();
    ticks(120);
    chk("psa_early", rst_req, 1'b0);
    ticks(16);
    chk("psa_late", rst_req, 1'b1);
    restart();
    wb(1'b1, ADDR_CFG, 32'h80);
    ticks(28);
    u_wwdt_core_model.issue(4);
    ticks(20);
    chk("win_ok", rst_req, 1'b0);
    u_wwdt_core_model.issue(4);
    ticks(2);
    chk("win_early", rst_req, 1'b1);
    rdchk(ADDR_STATUS, 32'h3, "early");
    $display("test window done");
    wb(1'b1, ADDR_CFG, 32'hc0);
    for (int k = 3; k >= 2; k--) begin
      restart();
      w = wakes;
      u_wwdt_core_model.issue(k);
      ticks(20);
      u_wwdt_core_model.issue(1);
      ticks(20);
      chk("no_wake", wakes - w, 0);
      ticks(16);
      chk("wake", wakes - w, 1);
      chk("no_rst", rst_req, 1'b0);
      rdchk(ADDR_RCR, 32'h10 | (32'h1 << k), "pwr");
    end
    $display("test power save done");
    wb(1'b1, ADDR_CFG, 32'h40);
    chk("sw_off", low_osc_en, 1'b0);
    wb(1'b1, ADDR_RCR, 32'h20);
    chk("sw_on", low_osc_en, 1'b1);
    u_wwdt_core_model.issue(4);
    ticks(36);
    chk("sw_rst", rst_req, 1'b1);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    rdchk(ADDR_RCR, 32'h0, "rcr_rst");
    chk("rst_req_clr", rst_req, 1'b0);
    $display("test soft enable done");
    end_sim();
  end
endmodule : test_windowed_watchdog_timer
